// >>> rtl/hv_wake_input_detector.sv
// High-voltage wake input detector with filters, bias and wake status
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ns
`default_nettype none

module hv_wake_input_detector
    import hv_wake_pkg::*;
#(
    parameter int NUM_HV = 3
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    input wire logic [NUM_HV-1:0] hv_wake_pin_i,
    input wire logic fail_out_pin_two_i,
    input wire logic fail_out_pin_three_i,
    input wire logic cyclic_timer_a_on_i,
    input wire logic cyclic_timer_b_on_i,
    input wire power_mode_t mode_i,
    output logic irq_o,
    output logic wake_o,
    output logic [NUM_HV-1:0] pull_up_en_o,
    output logic [NUM_HV-1:0] pull_dn_en_o
);

    localparam int NCH = NUM_HV + 2;

    // Field widths must fit one register word
    if (NUM_HV < 1 || 2 * NUM_HV > DATA_W) begin : g_bad_num_hv
        $error("NUM_HV must be 1 to 4");
    end

    // The long filter must fit the cycle counter
    if (FILT_LONG_CYC >= 2 ** CNT_W) begin : g_bad_cnt_w
        $error("CNT_W too narrow for the long filter");
    end

    // Filter length in cycles for a detection select code
    function automatic logic [CNT_W-1:0] filt_cycles(
        input logic [1:0] sel
    );
        if (sel == DET_STATIC_64) begin
            return CNT_W'(FILT_LONG_CYC);
        end
        return CNT_W'(FILT_SHORT_CYC);
    endfunction

    // Software registers
    logic [NCH-1:0] wake_pin_enable_ctrl;
    logic [NUM_HV-1:0] wake_source_status;
    logic [1:0] alt_input_wake_status;
    logic [NUM_HV-1:0] pin_level_status;
    logic [2*NUM_HV-1:0] pin_bias_ctrl;
    logic [2*NUM_HV-1:0] detect_filter_ctrl;

    // Pin synchronisers, two flops each
    logic [NCH-1:0] pin_meta;
    logic [NCH-1:0] pin_s;
    // Per-channel filter state
    logic [CNT_W-1:0] cnt [NCH];
    logic [NCH-1:0] stable;
    logic [NCH-1:0] edge_ev;
    logic [NCH-1:0] samp;
    logic primed;

    // Per-channel configuration wires
    logic [1:0] sel [NCH];
    logic [NCH-1:0] act;
    logic [NCH-1:0] cyc;
    logic [CNT_W-1:0] lim [NCH];

    // Bus decode
    wire logic wr_en = reg_wr_i && reg_addr_i == ADDR_WAKE_EN;
    wire logic wr_src = reg_wr_i && reg_addr_i == ADDR_WAKE_SRC;
    wire logic wr_alt = reg_wr_i && reg_addr_i == ADDR_ALT_WAKE;
    wire logic wr_bias = reg_wr_i && reg_addr_i == ADDR_BIAS;
    wire logic wr_det = reg_wr_i && reg_addr_i == ADDR_DETECT;

    // Wake events from enabled channels only
    wire logic [NCH-1:0] wake_ev = edge_ev & wake_pin_enable_ctrl;
    wire logic [NUM_HV-1:0] hv_ev = wake_ev[NUM_HV-1:0];
    wire logic [1:0] fo_ev = wake_ev[NCH-1:NUM_HV];
    wire logic any_ev = |wake_ev;
    wire logic awake_mode = mode_i == MODE_NORMAL || mode_i == MODE_STOP;

    // Write-one-to-clear masks
    wire logic [NUM_HV-1:0] src_clr =
        wr_src ? reg_wdata_i[NUM_HV-1:0] : '0;
    wire logic [1:0] alt_clr = wr_alt ? reg_wdata_i[1:0] : 2'h0;

    // Level shown: window sample for cyclic pins, live otherwise
    wire logic [NUM_HV-1:0] next_level =
        (cyc[NUM_HV-1:0] & samp[NUM_HV-1:0]) |
        (~cyc[NUM_HV-1:0] & pin_s[NUM_HV-1:0]);

    // Read multiplexer; unmapped addresses read zero
    logic [DATA_W-1:0] rd_mux;
    assign rd_mux =
        reg_addr_i == ADDR_WAKE_EN ? DATA_W'(wake_pin_enable_ctrl) :
        reg_addr_i == ADDR_WAKE_SRC ? DATA_W'(wake_source_status) :
        reg_addr_i == ADDR_PIN_LVL ? DATA_W'(pin_level_status) :
        reg_addr_i == ADDR_ALT_WAKE ? DATA_W'(alt_input_wake_status) :
        reg_addr_i == ADDR_BIAS ? DATA_W'(pin_bias_ctrl) :
        reg_addr_i == ADDR_DETECT ? DATA_W'(detect_filter_ctrl) :
        '0;

    // Two-flop synchroniser for all wake-capable pins; it runs
    // through reset so the filters prime on the real pin levels
    always_ff @(posedge core_clk_i) begin
        pin_meta <= {fail_out_pin_three_i, fail_out_pin_two_i,
            hv_wake_pin_i};
        pin_s <= pin_meta;
    end

    // Channel configuration and filter per pin
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        if (i < NUM_HV) begin : g_hv
            assign sel[i] = detect_filter_ctrl[2*i+:2];
            assign cyc[i] = sel[i][1];
            // Cyclic pins only listen during their timer window
            assign act[i] = !sel[i][1] ? 1'b1 :
                (sel[i] == DET_CYCLIC_A ? cyclic_timer_a_on_i
                : cyclic_timer_b_on_i);
        end else begin : g_fo
            // Fail-out pins as wake inputs: static, short filter
            assign sel[i] = DET_STATIC_16;
            assign cyc[i] = 1'b0;
            assign act[i] = wake_pin_enable_ctrl[i];
        end
        assign lim[i] = filt_cycles(sel[i]);

        // Filter: a crossing starts the count, crossing back clears it
        always_ff @(posedge core_clk_i) begin
            if (rst_i) begin
                cnt[i] <= '0;
                stable[i] <= 1'b0;
                edge_ev[i] <= 1'b0;
                samp[i] <= 1'b0;
            end else begin
                edge_ev[i] <= 1'b0;
                if (act[i]) begin
                    samp[i] <= pin_s[i];
                end
                if (!primed) begin
                    stable[i] <= pin_s[i];
                    cnt[i] <= '0;
                end else if (!act[i] || pin_s[i] == stable[i]) begin
                    cnt[i] <= '0;
                end else if (cnt[i] == lim[i] - 1'b1) begin
                    cnt[i] <= '0;
                    stable[i] <= pin_s[i];
                    edge_ev[i] <= 1'b1;
                end else begin
                    cnt[i] <= cnt[i] + 1'b1;
                end
            end
        end

        // Filter state checks for this channel
        a_filter_len: assert property (@(posedge core_clk_i)
            disable iff (rst_i)
            (primed && $past(primed) && $changed(stable[i])) |->
            $past(cnt[i]) == $past(lim[i]) - 1'b1 && edge_ev[i])
            else $error("Filter output changed before filter time");
        a_cross_back: assert property (@(posedge core_clk_i)
            disable iff (rst_i)
            (primed && pin_s[i] == stable[i]) |=> cnt[i] == '0)
            else $error("Filter count not restarted on crossing back");
        a_window_gate: assert property (@(posedge core_clk_i)
            disable iff (rst_i)
            (!act[i]) |=> cnt[i] == '0 && !edge_ev[i])
            else $error("Input evaluated outside sensing window");
    end

    // Settle filters on the pin levels after reset without events
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            primed <= 1'b0;
        end else begin
            primed <= 1'b1;
        end
    end

    // Control registers written by software
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wake_pin_enable_ctrl <= NCH'(RST_WAKE_EN);
            pin_bias_ctrl <= (2*NUM_HV)'(RST_BIAS);
            detect_filter_ctrl <= (2*NUM_HV)'(RST_DETECT);
        end else begin
            if (wr_en) begin
                wake_pin_enable_ctrl <= reg_wdata_i[NCH-1:0];
            end
            if (wr_bias) begin
                pin_bias_ctrl <= reg_wdata_i[2*NUM_HV-1:0];
            end
            if (wr_det) begin
                detect_filter_ctrl <= reg_wdata_i[2*NUM_HV-1:0];
            end
        end
    end

    // Sticky wake flags; a new event wins over a clear
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wake_source_status <= '0;
            alt_input_wake_status <= 2'h0;
        end else begin
            wake_source_status <=
                (wake_source_status & ~src_clr) | hv_ev;
            alt_input_wake_status <=
                (alt_input_wake_status & ~alt_clr) | fo_ev;
        end
    end

    // Level status follows pins only in normal and stop
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pin_level_status <= '0;
        end else if (awake_mode) begin
            pin_level_status <= next_level;
        end
    end

    // Interrupt pulse when awake, wake request when asleep
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            irq_o <= any_ev && awake_mode;
            if (awake_mode) begin
                wake_o <= 1'b0;
            end else if (any_ev) begin
                wake_o <= 1'b1;
            end
        end
    end

    // Current sources; auto mode follows the detected pin level
    for (genvar p = 0; p < NUM_HV; p++) begin : g_bias
        wire logic [1:0] bsel = pin_bias_ctrl[2*p+:2];
        always_ff @(posedge core_clk_i) begin
            if (rst_i) begin
                pull_up_en_o[p] <= 1'b0;
                pull_dn_en_o[p] <= 1'b0;
            end else begin
                pull_up_en_o[p] <= bsel == BIAS_UP ||
                    (bsel == BIAS_AUTO && pin_s[p]);
                pull_dn_en_o[p] <= bsel == BIAS_DOWN ||
                    (bsel == BIAS_AUTO && !pin_s[p]);
            end
        end

        // Current source checks for this pin
        a_auto_bias: assert property (@(posedge core_clk_i)
            disable iff (rst_i)
            (bsel == BIAS_AUTO) |=>
            pull_up_en_o[p] == $past(pin_s[p]) &&
            pull_dn_en_o[p] == !$past(pin_s[p]))
            else $error("Automatic bias does not follow pin level");
        a_bias_none: assert property (@(posedge core_clk_i)
            disable iff (rst_i)
            (bsel == BIAS_NONE) |=> !pull_up_en_o[p] && !pull_dn_en_o[p])
            else $error("Current source on with bias off");
        a_bias_up: assert property (@(posedge core_clk_i)
            disable iff (rst_i)
            (bsel == BIAS_UP) |=> pull_up_en_o[p] && !pull_dn_en_o[p])
            else $error("Pull-up setting not applied");
        a_bias_down: assert property (@(posedge core_clk_i)
            disable iff (rst_i)
            (bsel == BIAS_DOWN) |=> pull_dn_en_o[p] && !pull_up_en_o[p])
            else $error("Pull-down setting not applied");
    end

    // Registered read data, one cycle after the strobe
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
        end
    end

    // Wake signalling, flag and level status checks
    a_irq_awake: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        (any_ev && awake_mode) |=>
        irq_o ##1 (!irq_o || $past(any_ev && awake_mode)))
        else $error("Wake event in normal or stop gave no interrupt");
    a_irq_cause: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        irq_o |-> $past(any_ev && awake_mode))
        else $error("Interrupt without a wake event while awake");
    a_wake_asleep: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        (any_ev && !awake_mode) |=> wake_o && !irq_o)
        else $error("Wake event in sleep or fail-safe gave no wake");
    a_disabled_pin: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        (edge_ev[0] && !wake_pin_enable_ctrl[0] &&
        !wake_source_status[0]) |=> !wake_source_status[0])
        else $error("Disabled pin recorded as wake source");
    a_flag_sticky: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        (wake_source_status[0] && !(wr_src && reg_wdata_i[0]))
        |=> wake_source_status[0])
        else $error("Wake flag lost without software clear");
    a_flag_set: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        hv_ev[0] |=> wake_source_status[0])
        else $error("Wake event on pin not recorded");
    a_fo_flag: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        fo_ev[0] |=> alt_input_wake_status[0])
        else $error("Fail-out wake event not recorded");
    a_level_hold: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        (cyc[0] && !act[0] && $past(cyc[0] && !act[0]) && awake_mode)
        |=> $stable(pin_level_status[0]))
        else $error("Cyclic level changed outside on-window");
    a_level_frozen: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        !awake_mode |=> $stable(pin_level_status))
        else $error("Level status changed in sleep or fail-safe");

endmodule

`default_nettype wire

// >>> rtl/hv_wake_pkg.sv
// Constants and types shared by the high-voltage wake input detector
package hv_wake_pkg;

    // Core clock period and filter times
    localparam int CLK_PERIOD_NS = 100;
    localparam int FILT_SHORT_NS = 16000;
    localparam int FILT_LONG_NS = 64000;
    // Least times round up to whole cycles
    localparam int FILT_SHORT_CYC =
        (FILT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_LONG_CYC =
        (FILT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 10;

    // Register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register byte addresses
    localparam logic [7:0] ADDR_WAKE_EN = 8'h00;
    localparam logic [7:0] ADDR_WAKE_SRC = 8'h04;
    localparam logic [7:0] ADDR_PIN_LVL = 8'h08;
    localparam logic [7:0] ADDR_ALT_WAKE = 8'h0C;
    localparam logic [7:0] ADDR_BIAS = 8'h10;
    localparam logic [7:0] ADDR_DETECT = 8'h14;

    // Values after reset
    localparam logic [7:0] RST_WAKE_EN = 8'h00;
    localparam logic [7:0] RST_BIAS = 8'h00;
    localparam logic [7:0] RST_DETECT = 8'h00;

    // Detection select codes per pin
    localparam logic [1:0] DET_STATIC_16 = 2'h0;
    localparam logic [1:0] DET_STATIC_64 = 2'h1;
    localparam logic [1:0] DET_CYCLIC_A = 2'h2;
    localparam logic [1:0] DET_CYCLIC_B = 2'h3;

    // Bias select codes per pin
    localparam logic [1:0] BIAS_NONE = 2'h0;
    localparam logic [1:0] BIAS_DOWN = 2'h1;
    localparam logic [1:0] BIAS_UP = 2'h2;
    localparam logic [1:0] BIAS_AUTO = 2'h3;

    // Power modes of the surrounding device
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_STOP,
        MODE_SLEEP,
        MODE_FAIL_SAFE
    } power_mode_t;

endpackage

// >>> tb/wake_pins_model.sv
// Behavioural model of the switches and sensors on the wake pins
`timescale 1ns/1ns
`default_nettype none
module wake_pins_model (
    input wire logic core_clk_i,
    input wire logic [2:0] sw_on_i,
    input wire logic [2:0] sw_lvl_i,
    input wire logic [2:0] pull_up_i,
    input wire logic [2:0] pull_dn_i,
    output logic [2:0] pin_o
);
    logic [2:0] float_q = 3'h0;

    // An open, unbiased pin wanders every cycle
    always @(posedge core_clk_i) begin
        float_q <= ~pin_o;
    end

    // A closed switch wins, then the bias source, then the wander
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (sw_on_i[i]) begin
                pin_o[i] = sw_lvl_i[i];
            end else if (pull_up_i[i]) begin
                pin_o[i] = 1'b1;
            end else if (pull_dn_i[i]) begin
                pin_o[i] = 1'b0;
            end else begin
                pin_o[i] = float_q[i];
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/hv_wake_input_detector_tb.sv
// Self-checking bench for the high-voltage wake input detector
`timescale 1ns/1ns
`default_nettype none
module hv_wake_input_detector_tb;
    import hv_wake_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [7:0] d;
    logic [2:0] pin;
    logic [2:0] sw_lvl = 3'h0;
    logic fo2 = 1'b0;
    logic fo3 = 1'b0;
    logic tmr_a = 1'b0;
    logic tmr_b = 1'b0;
    power_mode_t mode = MODE_NORMAL;
    logic irq;
    logic wake;
    logic [2:0] pu;
    logic [2:0] pd;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_irq = 0;

    hv_wake_input_detector #(.NUM_HV(3)) i_hv_wake_input_detector (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .hv_wake_pin_i(pin),
        .fail_out_pin_two_i(fo2), .fail_out_pin_three_i(fo3),
        .cyclic_timer_a_on_i(tmr_a), .cyclic_timer_b_on_i(tmr_b),
        .mode_i(mode), .irq_o(irq), .wake_o(wake),
        .pull_up_en_o(pu), .pull_dn_en_o(pd));

    wake_pins_model i_wake_pins_model (.core_clk_i(core_clk_i),
        .sw_on_i(3'h7), .sw_lvl_i(sw_lvl), .pull_up_i(pu),
        .pull_dn_i(pd), .pin_o(pin));

    // Clock and irq pulse counter
    initial begin
        forever #50 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        if (irq === 1'b1) n_irq <= n_irq + 1;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Read strobe for one cycle, data taken in the cycle after
    task automatic chk_reg(input string what, input logic [7:0] a,
                           input logic [7:0] exp);
        @(posedge core_clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk_i);
        rd <= 1'b0;
        #1 d = rdata;
        chk(what, exp, d);
    endtask
    task automatic end_of_test();
        $display("n_tests %0d n_mismatch %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Reset values and an unmapped address
    task automatic t_reset();
        chk_reg("enable", ADDR_WAKE_EN, RST_WAKE_EN);
        chk_reg("bias", ADDR_BIAS, RST_BIAS);
        chk_reg("detect", ADDR_DETECT, RST_DETECT);
        chk_reg("unmapped", 8'h20, 8'h00);
        chk("pull_up", 8'h00, {5'h00, pu | pd});
    endtask
    // Short glitch refused, both edges wake, flags sticky
    task automatic t_static();
        wr_reg(ADDR_WAKE_EN, 8'h03);
        sw_lvl[0] <= 1'b1;
        cyc(100);
        sw_lvl[0] <= 1'b0;
        cyc(200);
        chk_reg("glitch", ADDR_WAKE_SRC, 8'h00);
        sw_lvl[0] <= 1'b1;
        cyc(200);
        chk_reg("rise", ADDR_WAKE_SRC, 8'h01);
        chk_reg("sticky", ADDR_WAKE_SRC, 8'h01);
        chk_reg("level", ADDR_PIN_LVL, 8'h01);
        wr_reg(ADDR_WAKE_SRC, 8'h01);
        chk_reg("cleared", ADDR_WAKE_SRC, 8'h00);
        sw_lvl[0] <= 1'b0;
        cyc(200);
        chk_reg("fall", ADDR_WAKE_SRC, 8'h01);
        wr_reg(ADDR_WAKE_SRC, 8'h01);
    endtask
    // Long filter on pin 1, pin 2 disabled
    task automatic t_long();
        wr_reg(ADDR_DETECT, 8'h04);
        sw_lvl[2:1] <= 2'h3;
        cyc(400);
        chk_reg("long early", ADDR_WAKE_SRC, 8'h00);
        cyc(300);
        chk_reg("long late", ADDR_WAKE_SRC, 8'h02);
        chk_reg("level", ADDR_PIN_LVL, 8'h06);
        wr_reg(ADDR_WAKE_SRC, 8'h02);
    endtask
    // Interrupt in normal and stop, wake in sleep and fail-safe
    task automatic t_modes();
        int n;
        for (int m = 0; m < 4; m++) begin
            mode <= power_mode_t'(m);
            n = n_irq;
            sw_lvl[0] <= ~sw_lvl[0];
            cyc(200);
            chk("wake", {7'h00, m > 1}, {7'h00, wake});
            chk("irq", {7'h00, m < 2}, 8'(n_irq - n));
            mode <= MODE_NORMAL;
            cyc(3);
            chk("wake off", 8'h00, {7'h00, wake});
            wr_reg(ADDR_WAKE_SRC, 8'h01);
        end
    endtask
    // Every bias code on all pins
    task automatic t_bias();
        logic [2:0] up;
        logic [2:0] dn;
        for (int c = 0; c < 4; c++) begin
            wr_reg(ADDR_BIAS, {2'h0, 2'(c), 2'(c), 2'(c)});
            cyc(4);
            up = (c == 2) ? 3'h7 : (c == 3) ? pin : 3'h0;
            dn = (c == 1) ? 3'h7 : (c == 3) ? ~pin : 3'h0;
            chk("pull_up", {5'h00, up}, {5'h00, pu});
            chk("pull_dn", {5'h00, dn}, {5'h00, pd});
        end
    endtask
    // Cyclic sensing on both timers, sampled level shown
    task automatic t_cyclic();
        wr_reg(ADDR_DETECT, 8'h06);
        sw_lvl[0] <= 1'b1;
        cyc(200);
        chk_reg("closed", ADDR_WAKE_SRC, 8'h00);
        chk_reg("held lvl", ADDR_PIN_LVL, 8'h06);
        tmr_a <= 1'b1;
        cyc(200);
        chk_reg("open", ADDR_WAKE_SRC, 8'h01);
        tmr_a <= 1'b0;
        sw_lvl[0] <= 1'b0;
        cyc(5);
        chk_reg("sampled", ADDR_PIN_LVL, 8'h07);
        wr_reg(ADDR_WAKE_SRC, 8'h01);
        wr_reg(ADDR_DETECT, 8'h07);
        tmr_b <= 1'b1;
        cyc(200);
        chk_reg("timer b", ADDR_WAKE_SRC, 8'h01);
    endtask
    // Fail-out pin two as wake input, three left off
    task automatic t_failout();
        wr_reg(ADDR_WAKE_SRC, 8'h01);
        wr_reg(ADDR_WAKE_EN, 8'h08);
        cyc(5);
        fo2 <= 1'b1;
        fo3 <= 1'b1;
        sw_lvl[0] <= 1'b1;
        cyc(200);
        chk_reg("alt", ADDR_ALT_WAKE, 8'h01);
        chk_reg("disabled", ADDR_WAKE_SRC, 8'h00);
        wr_reg(ADDR_ALT_WAKE, 8'h01);
        chk_reg("alt cleared", ADDR_ALT_WAKE, 8'h00);
    endtask
    // Reset in mid-run with pins high: no false wake afterwards
    task automatic t_rerun();
        @(posedge core_clk_i);
        rst_i <= 1'b1;
        cyc(2);
        rst_i <= 1'b0;
        wr_reg(ADDR_WAKE_EN, 8'h07);
        cyc(200);
        chk_reg("no false wake", ADDR_WAKE_SRC, 8'h00);
        chk_reg("level kept", ADDR_PIN_LVL, 8'h07);
        chk_reg("alt reset", ADDR_ALT_WAKE, 8'h00);
    endtask

    // Watchdog well beyond the planned run
    initial begin
        #(20000 * 100);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        cyc(5);
        rst_i <= 1'b0;
        t_reset();
        t_static();
        t_long();
        t_modes();
        t_bias();
        t_cyclic();
        t_failout();
        t_rerun();
        end_of_test();
    end
endmodule
`default_nettype wire
